// ===== common/vdsc_pkg.sv
// Constants, timing and decode values for the VME DRAM slave control block
package vdsc_pkg;
  localparam int CLK_NS        = 25;
  localparam int REF_PERIOD_NS = 14000;
  localparam int REF_LEN_NS    = 292;
  localparam int WR_ACC_NS     = 215;
  localparam int RD_ACC_NS     = 255;
  localparam int PAR_NS        = 80;
  localparam int WR_MIN_NS     = 333;
  localparam int RD_MIN_NS     = 460;
  localparam int REF_PERIOD    = REF_PERIOD_NS / CLK_NS;
  localparam int REF_LEN       = (REF_LEN_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_ACC        = (WR_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_ACC        = (RD_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int PAR_CYC       = (PAR_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_MIN        = (WR_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_MIN        = (RD_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W         = 5;
  localparam int REF_W         = 10;
  localparam int MBASE_W       = 13;
  localparam logic [5:0] AM_SIO = 6'h2d;
  localparam logic [5:0] AM_SSP = 6'h3e;
  localparam logic [5:0] AM_SSD = 6'h3d;
  localparam logic [5:0] AM_SNP = 6'h3a;
  localparam logic [5:0] AM_SND = 6'h39;
  localparam logic [5:0] AM_ESP = 6'h0e;
  localparam logic [5:0] AM_ESD = 6'h0d;
  localparam logic [5:0] AM_ENP = 6'h0a;
  localparam logic [5:0] AM_END = 6'h09;
  localparam logic [7:0] IO_VEC   = 8'h01;
  localparam logic [7:0] IO_CTRL  = 8'h03;
  localparam logic [7:0] IO_ADRH  = 8'h01;
  localparam logic [7:0] IO_ADRM  = 8'h03;
  localparam logic [7:0] IO_ADRL  = 8'h05;
  localparam int CTRL_IEN  = 0;
  localparam int CTRL_FERR = 1;
  localparam logic [7:0] AHB_CFG  = 8'h00;
  localparam logic [7:0] AHB_STAT = 8'h04;
  localparam logic [7:0] AHB_ELOG = 8'h08;
  localparam int CFG_2M   = 0;
  localparam int CFG_BERP = 1;
  localparam int CFG_A24  = 2;
  localparam logic [2:0] DEF_LEVEL = 3'h6;
  localparam logic [7:0] IO_JMP_RST = 8'h00;
endpackage

// ===== logic/vdsc_top.sv
// VME DRAM slave control: decode, refresh, parity error handling, interrupter
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module vdsc_top (
  input  wire logic                          i_mclk,
  input  wire logic                          i_reset_n,
  input  wire logic                          i_hsel,
  input  wire logic [31:0]                   i_haddr,
  input  wire logic [1:0]                    i_htrans,
  input  wire logic                          i_hwrite,
  input  wire logic [2:0]                    i_hsize,
  input  wire logic [31:0]                   i_hwdata,
  input  wire logic                          i_hready,
  output logic      [31:0]                   o_hrdata,
  output logic                               o_hreadyout,
  output logic                               o_hresp,
  input  wire logic                          i_as_n,
  input  wire logic [1:0]                    i_ds_n,
  input  wire logic                          i_write_n,
  input  wire logic                          i_lword_n,
  input  wire logic [5:0]                    i_am,
  input  wire logic [31:1]                   i_addr,
  input  wire logic                          i_iack_n,
  input  wire logic                          i_iackin_n,
  input  wire logic [7:0]                    i_data,
  input  wire logic [3:0]                    i_bg_in_n,
  input  wire logic [vdsc_pkg::MBASE_W-1:0]  i_mem_jmp,
  input  wire logic [7:0]                    i_io_jmp,
  input  wire logic [2:0]                    i_irq_level,
  input  wire logic                          i_par_err,
  output logic                               o_dtack_n,
  output logic                               o_berr_n,
  output logic      [7:1]                    o_irq_n,
  output logic                               o_iackout_n,
  output logic      [3:0]                    o_bg_out_n,
  output logic      [7:0]                    o_data,
  output logic                               o_data_oe,
  output logic                               o_mem_req,
  output logic                               o_mem_wr,
  output logic                               o_refresh
);
  import vdsc_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_REF, ST_MEM, ST_ACK, ST_ERR, ST_PASS} vdsc_state_t;

  localparam int SW = 80;
  localparam logic [SW-1:0] SYNC_RST = {{(SW-8){1'b1}}, IO_JMP_RST};

  function automatic logic vdsc_am_mem(input logic [5:0] am);
    return am inside {AM_SSP, AM_SSD, AM_SNP, AM_SND, AM_ESP, AM_ESD, AM_ENP, AM_END};
  endfunction

  // Every bus pin and jumper crosses in through two flops
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  wire  [SW-1:0] raw = {i_as_n, i_ds_n, i_write_n, i_lword_n, i_am, i_addr, i_iack_n,
                        i_iackin_n, i_data, i_bg_in_n, i_mem_jmp, i_irq_level, i_io_jmp};
  always_ff @(posedge i_mclk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
    end

  wire              s_as_n, s_write_n, s_lword_n, s_iack_n, s_iackin_n;
  wire [1:0]        s_ds_n;
  wire [5:0]        s_am;
  wire [31:1]       a;
  wire [7:0]        s_data, s_io_jmp;
  wire [3:0]        s_bg_n;
  wire [MBASE_W-1:0] s_mem_jmp;
  wire [2:0]        s_lvl;
  assign {s_as_n, s_ds_n, s_write_n, s_lword_n, s_am, a, s_iack_n, s_iackin_n, s_data,
          s_bg_n, s_mem_jmp, s_lvl, s_io_jmp} = s2_q;

  vdsc_state_t      st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, min_q;
  logic [REF_W-1:0] ref_cnt_q;
  logic             ref_pend_q, pend_q, ien_q, ferr_q;
  logic [7:0]       vec_q;
  logic [23:0]      elog_q;
  logic [2:0]       cfg_q;
  logic             ahb_wr_q;
  logic [7:0]       ahb_adr_q;

  // Base jumpers read inverted: inserted gives 0; the level is not inverted, and 0 selects DEF_LEVEL
  wire [MBASE_W-1:0] mbase  = ~s_mem_jmp;
  wire [7:0]         iobase = ~s_io_jmp;
  wire [2:0]         irq_lvl = (s_lvl == 3'h0) ? DEF_LEVEL : s_lvl;

  wire       as     = ~s_as_n;
  wire [1:0] ds     = ~s_ds_n;
  wire       ds_any = |ds;
  wire       ext    = (s_am[5:4] == 2'b00);
  wire       cmp_lo = cfg_q[CFG_2M] | (a[20:19] == mbase[1:0]);
  wire       cmp_md = (a[23:21] == mbase[4:2]);
  // Standard cycles carry no upper bits; software may also drop them
  wire       cmp_hi = cfg_q[CFG_A24] | ~ext | (a[31:24] == mbase[12:5]);
  wire       mem_hit = as & s_iack_n & vdsc_am_mem(s_am) & cmp_lo & cmp_md & cmp_hi;
  wire       lw_bad  = ~s_lword_n & (a[1] | ~&ds);
  wire       byte_ds = ds[0] ^ ds[1];
  wire       io_hit  = as & s_iack_n & (s_am == AM_SIO) & (a[15:8] == iobase)
                       & s_lword_n & byte_ds;
  wire [7:0] io_off  = {a[7:1], ds[0]};
  wire       idle    = (st_q == ST_IDLE);
  wire       go_ref  = idle & ref_pend_q;
  wire       go_mem  = idle & ~ref_pend_q & ds_any & mem_hit;
  wire       go_io   = idle & ~ref_pend_q & ds_any & ~mem_hit & io_hit;
  wire       go_iak  = idle & ~ref_pend_q & ds_any & as & ~s_iack_n & ~s_iackin_n;
  wire       iak_me  = go_iak & pend_q & (a[3:1] == irq_lvl);
  wire [CNT_W-1:0] acc_len = ~s_write_n ? CNT_W'(WR_ACC)
                           : CNT_W'(RD_ACC) + (cfg_q[CFG_BERP] ? CNT_W'(PAR_CYC) : '0);
  wire [CNT_W-1:0] min_len = ~s_write_n ? CNT_W'(WR_MIN) : CNT_W'(RD_MIN);
  wire       mem_done = (st_q == ST_MEM) & (cnt_q == acc_len - CNT_W'(1));
  // Forced error lets software exercise the interrupter and logger
  wire       par_hit = mem_done & s_write_n & (i_par_err | ferr_q);
  wire       err_set = par_hit & ien_q;
  wire       berr_par = par_hit & cfg_q[CFG_BERP];
  wire [7:0] io_rd = (io_off == IO_ADRH) ? elog_q[15:8]
                   : (io_off == IO_ADRM) ? elog_q[7:0]
                   : (io_off == IO_ADRL) ? elog_q[23:16] : 8'h00;

  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ST_IDLE:
      begin
        cnt_d = '0;
        if (go_ref)
          st_d = ST_REF;
        else if (go_mem)
          st_d = lw_bad ? ST_ERR : ST_MEM;
        else if (go_io || iak_me)
          st_d = ST_ACK;
        else if (go_iak)
          st_d = ST_PASS;
      end
      ST_REF:
      begin
        cnt_d = cnt_q + CNT_W'(1);
        if (cnt_q == CNT_W'(REF_LEN - 1))
          st_d = ST_IDLE;
      end
      ST_MEM:
      begin
        cnt_d = cnt_q + CNT_W'(1);
        if (mem_done)
          st_d = berr_par ? ST_ERR : ST_ACK;
      end
      ST_ACK:
      begin
        if (cnt_q < min_q)
          cnt_d = cnt_q + CNT_W'(1);
        // Recovery keeps cycles at their minimum spacing
        if (!ds_any && cnt_q >= min_q)
          st_d = ST_IDLE;
      end
      ST_ERR:
        if (!ds_any)
          st_d = ST_IDLE;
      ST_PASS:
        if (!as)
          st_d = ST_IDLE;
      default:
        st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      st_q       <= ST_IDLE;
      cnt_q      <= '0;
      min_q      <= '0;
      ref_cnt_q  <= '0;
      ref_pend_q <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      if (go_mem)
        min_q <= min_len;
      else if (idle)
        min_q <= '0;
      ref_cnt_q <= (ref_cnt_q == REF_W'(REF_PERIOD - 1)) ? '0 : ref_cnt_q + REF_W'(1);
      ref_pend_q <= (ref_cnt_q == REF_W'(REF_PERIOD - 1)) | (ref_pend_q & ~go_ref);
    end

  // Control space, error log and pending request
  always_ff @(posedge i_mclk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      vec_q  <= 8'h00;
      ien_q  <= 1'b0;
      ferr_q <= 1'b0;
      pend_q <= 1'b0;
      elog_q <= '0;
    end
    else
    begin
      if (go_io && !s_write_n && io_off == IO_VEC)
        vec_q <= s_data;
      if (go_io && !s_write_n && io_off == IO_CTRL)
      begin
        ien_q  <= s_data[CTRL_IEN];
        ferr_q <= s_data[CTRL_FERR];
      end
      // A new error in the acknowledge cycle keeps the request up
      pend_q <= err_set | (pend_q & ~iak_me);
      if (err_set)
        elog_q <= {s_lword_n, a[21:15], a[14:7], a[6:1], s_ds_n};
    end

  // Bus-facing outputs, all registered
  always_ff @(posedge i_mclk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      o_dtack_n   <= 1'b1;
      o_berr_n    <= 1'b1;
      o_irq_n     <= '1;
      o_iackout_n <= 1'b1;
      o_bg_out_n  <= '1;
      o_data      <= 8'h00;
      o_data_oe   <= 1'b0;
      o_mem_req   <= 1'b0;
      o_mem_wr    <= 1'b0;
      o_refresh   <= 1'b0;
    end
    else
    begin
      o_dtack_n   <= ~((st_d == ST_ACK) & ds_any);
      o_berr_n    <= ~((st_d == ST_ERR) & ds_any);
      for (int l = 1; l < 8; l++)
        o_irq_n[l] <= ~(pend_q & (irq_lvl == 3'(l)));
      o_iackout_n <= ~(st_d == ST_PASS);
      o_bg_out_n  <= s_bg_n;
      if (go_io && s_write_n)
        o_data <= io_rd;
      else if (iak_me)
        o_data <= vec_q;
      o_data_oe   <= (st_d == ST_ACK) & (o_data_oe | (go_io & s_write_n) | iak_me);
      o_mem_req   <= (st_d == ST_MEM) | ((st_d == ST_ACK) & (min_q != '0));
      o_mem_wr    <= ~s_write_n;
      o_refresh   <= (st_d == ST_REF);
    end

  // AHB-Lite slave, zero wait states
  wire ahb_go = i_hsel & i_htrans[1] & i_hready;
  always_ff @(posedge i_mclk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      ahb_wr_q    <= 1'b0;
      ahb_adr_q   <= 8'h00;
      cfg_q       <= '0;
      o_hrdata    <= '0;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
    else
    begin
      ahb_wr_q  <= ahb_go & i_hwrite;
      ahb_adr_q <= i_haddr[7:0];
      if (ahb_wr_q && ahb_adr_q == AHB_CFG)
        cfg_q <= i_hwdata[2:0];
      if (ahb_go && !i_hwrite)
        o_hrdata <= (i_haddr[7:0] == AHB_CFG)  ? {29'h0, cfg_q}
                  : (i_haddr[7:0] == AHB_STAT) ? {15'h0, o_refresh, vec_q, 5'h0, ferr_q,
                                                  ien_q, pend_q}
                  : (i_haddr[7:0] == AHB_ELOG) ? {8'h0, elog_q} : 32'h0;
    end

  a_ref_length: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(o_refresh) |-> o_refresh[*8] ##1 o_refresh[*4] ##1 !o_refresh)
    else $error("refresh length wrong");
  a_ref_holdoff: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_refresh |-> !o_mem_req) else $error("memory request during refresh");
  a_lword_berr: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    go_mem && lw_bad |=> !o_berr_n && o_dtack_n) else $error("illegal longword not errored");
  a_parity_berr: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    berr_par |=> !o_berr_n && o_dtack_n) else $error("parity bus error missing");
  a_irq_level: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    pend_q |=> o_irq_n[$past(irq_lvl)] == 1'b0) else $error("irq level wrong");
  a_dtack_release: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !ds_any |=> o_dtack_n && o_berr_n) else $error("acknowledge held after strobes");
  a_grant_pass: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $past(i_reset_n, 3) |-> o_bg_out_n == $past(i_bg_in_n, 3)) else $error("grant not passed");
  a_vector_write: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    vec_q != $past(vec_q) |-> $past(s_am) == AM_SIO && !$past(s_write_n))
    else $error("vector changed without short I/O write");
  a_io_read_am: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(o_data_oe) |-> $past(s_am) == AM_SIO || !$past(s_iack_n))
    else $error("control read without modifier 2D");
  a_parity_log: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    err_set |=> pend_q ##1 o_irq_n != '1) else $error("parity error not requested");
endmodule

// ===== sim/vdsc_vme_master.sv
// Behavioural VMEbus master that runs single cycles against the slave pins
`timescale 1ns/100ps
module vdsc_vme_master (
  input  wire logic        i_clk,
  input  wire logic        i_dtack_n,
  input  wire logic        i_berr_n,
  input  wire logic [7:0]  i_rd,
  output logic             o_as_n,
  output logic [1:0]       o_ds_n,
  output logic             o_write_n,
  output logic             o_lword_n,
  output logic [5:0]       o_am,
  output logic [31:1]      o_addr,
  output logic             o_iack_n,
  output logic             o_iackin_n,
  output logic [7:0]       o_wd
);
  initial
  begin
    o_as_n     = 1'b1;
    o_ds_n     = 2'h3;
    o_write_n  = 1'b1;
    o_lword_n  = 1'b1;
    o_am       = 6'h00;
    o_addr     = '0;
    o_iack_n   = 1'b1;
    o_iackin_n = 1'b1;
    o_wd       = 8'ha5;
  end

  // Resp is {berr, dtack}; 0 means no answer within the bound
  task automatic cycle(input logic [5:0] am, input logic [31:0] a, input logic lw_n,
                       input logic [1:0] ds, input logic wr_n, input logic [7:0] wd,
                       input logic ack, output logic [1:0] resp, output logic [7:0] rd);
    int n;
    n = 0;
    o_am       <= am;
    o_addr     <= a[31:1];
    o_lword_n  <= lw_n;
    o_write_n  <= wr_n;
    o_iack_n   <= ~ack;
    o_iackin_n <= ~ack;
    o_wd       <= wr_n ? ~o_wd : wd;
    o_as_n     <= 1'b0;
    o_ds_n     <= ds;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (i_dtack_n && i_berr_n && n < 60);
    resp = {~i_berr_n, ~i_dtack_n};
    rd   = i_rd;
    o_as_n     <= 1'b1;
    o_ds_n     <= 2'h3;
    o_iack_n   <= 1'b1;
    o_iackin_n <= 1'b1;
    // Released lines float to their terminator level
    o_am       <= 6'h3f;
    o_addr     <= '1;
    o_write_n  <= 1'b1;
    o_lword_n  <= 1'b1;
    o_wd       <= 8'hff;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while ((!i_dtack_n || !i_berr_n) && n < 20);
    // Idle gap keeps the next cycle beyond the minimum cycle time
    repeat (20) @(posedge i_clk);
  endtask
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the VME DRAM slave control block
`timescale 1ns/100ps
module tb_top;
  import vdsc_pkg::*;
  logic         mclk = 1'b0;
  logic         reset_n = 1'b0;
  logic         hsel = 1'b0;
  logic [31:0]  haddr = '0;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'b0;
  logic [31:0]  hwdata = '0;
  wire  [31:0]  hrdata;
  wire          hready;
  wire          hresp;
  wire          as_n, write_n, lword_n, iack_n, iackin_n;
  wire  [1:0]   ds_n;
  wire  [5:0]   am;
  wire  [31:1]  addr;
  wire  [7:0]   vdata, rdata;
  wire          dtack_n, berr_n, iackout_n, data_oe, mem_req, mem_wr, refresh;
  wire  [7:1]   irq_n;
  wire  [3:0]   bg_out_n;
  logic [3:0]   bg_in_n = 4'hf;
  logic         par_err = 1'b0;
  logic [12:0]  mem_jmp = 13'h1fff;
  logic [7:0]   io_jmp = 8'h00;
  logic [2:0]   lvl = 3'h0;
  logic [3:0]   seen = 4'h0;
  logic [1:0]   r;
  logic [7:0]   d;
  logic [31:0]  w;
  int           bad_count = 0;
  int           checks = 0;
  int           n;
  logic [5:0]   mem_am [8] = '{AM_SSP, AM_SSD, AM_SNP, AM_SND, AM_ESP, AM_ESD, AM_ENP, AM_END};

  always #12.5 mclk = ~mclk;

  // Sticky record of strobes that no cycle result shows directly
  always @(posedge mclk)
    if (reset_n)
      seen <= seen | {~iackout_n, data_oe, mem_req, mem_wr};

  vdsc_top dut (.i_mclk(mclk), .i_reset_n(reset_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_as_n(as_n), .i_ds_n(ds_n),
    .i_write_n(write_n), .i_lword_n(lword_n), .i_am(am), .i_addr(addr), .i_iack_n(iack_n),
    .i_iackin_n(iackin_n), .i_data(vdata), .i_bg_in_n(bg_in_n), .i_mem_jmp(mem_jmp),
    .i_io_jmp(io_jmp), .i_irq_level(lvl), .i_par_err(par_err), .o_dtack_n(dtack_n),
    .o_berr_n(berr_n), .o_irq_n(irq_n), .o_iackout_n(iackout_n), .o_bg_out_n(bg_out_n),
    .o_data(rdata), .o_data_oe(data_oe), .o_mem_req(mem_req), .o_mem_wr(mem_wr),
    .o_refresh(refresh));

  vdsc_vme_master master (.i_clk(mclk), .i_dtack_n(dtack_n), .i_berr_n(berr_n), .i_rd(rdata),
    .o_as_n(as_n), .o_ds_n(ds_n), .o_write_n(write_n), .o_lword_n(lword_n), .o_am(am),
    .o_addr(addr), .o_iack_n(iack_n), .o_iackin_n(iackin_n), .o_wd(vdata));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: bus answer %b, wanted %b", $time, got, exp);
    end
  endtask

  // Single AHB-Lite transfer; read data taken at the data phase edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk); while (!hready);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (!hready);
    w = hrdata;
  endtask

  task automatic vc(input logic [5:0] am_c, input logic [31:0] a, input logic lw_n,
                    input logic [1:0] ds, input logic wr_n, input logic [7:0] wd,
                    input logic ack, input logic [1:0] exp_r);
    master.cycle(am_c, a, lw_n, ds, wr_n, wd, ack, r, d);
    chk_r(r, exp_r);
  endtask

  initial
  begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_v({dtack_n, berr_n, hresp, irq_n}, {3'b110, 7'h7f});
    ahb(1'b0, {24'h0, AHB_CFG}, '0);
    chk_v(w, 32'h0);
    bg_in_n <= 4'h5;
    repeat (6) @(posedge mclk);
    chk_v(bg_out_n, 4'h5);
    bg_in_n <= 4'ha;
    repeat (6) @(posedge mclk);
    chk_v(bg_out_n, 4'ha);
    vc(AM_SSD, 32'h0, 1'b1, 2'h0, 1'b0, 8'h3c, 1'b0, 2'b01);
    for (int i = 0; i < 8; i++)
      vc(mem_am[i], 32'h4, 1'b0, 2'h0, 1'b1, 8'h0, 1'b0, 2'b01);
    // A20 set: outside a 512 Kbyte window, inside a 2 Mbyte one
    vc(AM_SSD, 32'h100000, 1'b1, 2'h0, 1'b0, 8'h11, 1'b0, 2'b00);
    mem_jmp <= 13'h1ffe;
    vc(AM_SSD, 32'h80000, 1'b1, 2'h0, 1'b0, 8'h11, 1'b0, 2'b01);
    mem_jmp <= 13'h1fff;
    ahb(1'b1, {24'h0, AHB_CFG}, 32'h1);
    vc(AM_SSD, 32'h100000, 1'b1, 2'h0, 1'b0, 8'h11, 1'b0, 2'b01);
    vc(AM_SSD, 32'h1000000, 1'b1, 2'h0, 1'b1, 8'h0, 1'b0, 2'b01);
    vc(AM_ESD, 32'h1000000, 1'b1, 2'h0, 1'b1, 8'h0, 1'b0, 2'b00);
    vc(AM_SSD, 32'h2, 1'b0, 2'h0, 1'b1, 8'h0, 1'b0, 2'b10);
    vc(6'h29, 32'hff00, 1'b1, 2'b10, 1'b0, 8'h77, 1'b0, 2'b00);
    vc(AM_SIO, 32'hfe00, 1'b1, 2'b10, 1'b0, 8'h77, 1'b0, 2'b00);
    io_jmp <= 8'h01;
    vc(AM_SIO, 32'hfe04, 1'b1, 2'b10, 1'b1, 8'h0, 1'b0, 2'b01);
    chk_v(d, 8'h00);
    io_jmp <= 8'h00;
    vc(AM_SIO, 32'hff00, 1'b1, 2'b10, 1'b0, 8'h5a, 1'b0, 2'b01);
    ahb(1'b0, {24'h0, AHB_STAT}, '0);
    chk_v(w[15:8], 8'h5a);
    vc(AM_SIO, 32'hff02, 1'b1, 2'b10, 1'b0, 8'h01, 1'b0, 2'b01);
    par_err <= 1'b1;
    vc(AM_SSD, 32'h4080, 1'b1, 2'h0, 1'b1, 8'h0, 1'b0, 2'b01);
    par_err <= 1'b0;
    chk_v(irq_n, 7'h5f);
    vc(AM_SIO, 32'hff00, 1'b1, 2'b10, 1'b1, 8'h0, 1'b0, 2'b01);
    chk_v(d, 8'h81);
    vc(AM_SIO, 32'hff04, 1'b1, 2'b10, 1'b1, 8'h0, 1'b0, 2'b01);
    chk_v(d, 8'h80);
    vc(AM_SIO, 32'ha, 1'b1, 2'b10, 1'b1, 8'h0, 1'b1, 2'b00);
    vc(AM_SIO, 32'hc, 1'b1, 2'b10, 1'b1, 8'h0, 1'b1, 2'b01);
    chk_v({d, irq_n}, {8'h5a, 7'h7f});
    ahb(1'b1, {24'h0, AHB_CFG}, 32'h2);
    par_err <= 1'b1;
    vc(AM_SSD, 32'h8, 1'b1, 2'h0, 1'b1, 8'h0, 1'b0, 2'b10);
    par_err <= 1'b0;
    lvl <= 3'h3;
    repeat (4) @(posedge mclk);
    chk_v(irq_n, 7'h7b);
    vc(AM_SIO, 32'h6, 1'b1, 2'b10, 1'b1, 8'h0, 1'b1, 2'b01);
    chk_v(d, 8'h5a);
    n = 0;
    while (refresh !== 1'b1 && n < 800)
    begin
      @(posedge mclk);
      n++;
    end
    n = 0;
    while (refresh === 1'b1 && n < 40)
    begin
      @(posedge mclk);
      n++;
    end
    chk_v(n, REF_LEN);
    chk_v(seen, 4'hf);
    print_verdict();
  end

  // Whole sequence needs a few thousand cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("unexpected at %0t: run did not finish", $time);
    print_verdict();
  end
endmodule
